// ---- cable_test_engine_model.sv ----
// Purpose: Far-side cable measurement engine that answers each launch pulse.
// Assumes: One clock; fail_sel_i picks the verdict of the next measurement.
// Notes: The fail line carries a toggling pattern outside the end cycle.
`timescale 1ns/10ps
`default_nettype none
module cable_test_engine_model #(
  parameter int DELAY = 7
) (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic fail_sel_i,
  output logic end_o,
  output logic fail_o
);
  int cnt_q = 0;
  logic tog_q = 1'b0;
  // The toggle keeps a stale verdict from passing as a sampled one.
  always_ff @(posedge clk_i) begin
    tog_q <= ~tog_q;
    if (start_i) begin
      cnt_q <= DELAY;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  assign end_o = (cnt_q == 1);
  assign fail_o = end_o ? fail_sel_i : tog_q;
endmodule
`default_nettype wire

// ---- phy_cfg_chk.sv ----
// Purpose: Port-level timing and value checks on the register bank.
// Assumes: Clock enable stays high while requests are made.
// Notes: Bound into every instance of the register bank.
`timescale 1ns/10ps
`default_nettype none
module phy_cfg_chk #(
  parameter int RESTART_CYCLES = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic irq_o,
  input wire logic irq_or_powerdown_pad_o,
  input wire logic partner_forced_100_i,
  input wire logic ieee_full_duplex_i,
  input wire logic full_duplex_o,
  input wire logic robust_mdix_o,
  input wire logic [8:0] crossover_retry_period_o,
  input wire logic cable_test_start_o,
  input wire logic core_restart_o,
  input wire logic [3:0] test_lane_enable_o
);
  int run_q;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i) begin
    if (rst_i || !core_restart_o) begin
      run_q <= 0;
    end else begin
      run_q <= run_q + 1;
    end
  end
  sequence s_request;
    cyc_i && stb_i && !ack_o && ce_i;
  endsequence
  sequence s_single_ack;
    ack_o ##1 !ack_o;
  endsequence
  a_ack_next_cycle: assert property (s_request |=> s_single_ack)
    else $error("bus request not answered by a single ack");
  a_pad_inverts_irq: assert property (irq_or_powerdown_pad_o == !irq_o)
    else $error("pad level does not mirror interrupt");
  a_duplex_follows_std: assert property ((ce_i && !partner_forced_100_i) |=>
    full_duplex_o == $past(ieee_full_duplex_i))
    else $error("duplex differs from standard resolution");
  a_retry_gated_off: assert property (!robust_mdix_o |-> crossover_retry_period_o == 9'h000)
    else $error("retry period shown without robust crossover");
  a_retry_step_range: assert property (robust_mdix_o |->
    crossover_retry_period_o >= 32 && crossover_retry_period_o <= 480 &&
    crossover_retry_period_o[4:0] == 5'h00)
    else $error("retry period off the step grid");
  a_launch_one_cycle: assert property (cable_test_start_o |=> !cable_test_start_o)
    else $error("launch pulse longer than one cycle");
  a_lane_select_legal: assert property ((!$past(rst_i) && !$past(rst_i, 2)) |->
    ($onehot(test_lane_enable_o) || test_lane_enable_o == 4'hf))
    else $error("illegal lane enable pattern");
  a_restart_length: assert property ($fell(core_restart_o) |-> run_q == RESTART_CYCLES)
    else $error("restart pulse of wrong length");
endmodule
bind phy_config_control_regs phy_cfg_chk #(
  .RESTART_CYCLES(RESTART_CYCLES)
) u_chk (.*);
`default_nettype wire

// ---- phy_cfg_pkg.sv ----
// Purpose: Shared constants for the transceiver configuration and control register bank.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes: Reset pulse counts are in cycles of the 200 MHz register clock; retry periods are in ms.
package phy_cfg_pkg;
  localparam logic [5:0] IDX_CONFIG_THREE = 6'h1e;
  localparam logic [5:0] IDX_SOFT_RESET_CONTROL = 6'h1f;
  localparam logic [5:0] IDX_TEST_LANE_CONTROL = 6'h25;
  localparam logic [5:0] IDX_CROSSOVER_RETRY_TIMER_CONFIG = 6'h2c;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h30;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h31;

  localparam int BIT_EXT_FULL_DUPLEX = 11;
  localparam int BIT_ROBUST_MDIX = 9;
  localparam int BIT_FAST_MDIX = 8;
  localparam int BIT_IRQ_OUT_ENABLE = 7;
  localparam int BIT_FORCE_IRQ = 6;
  localparam int BIT_CABLE_TEST_FAILED = 2;
  localparam int BIT_CABLE_TEST_COMPLETE = 1;
  localparam int BIT_CABLE_TEST_LAUNCH = 0;
  localparam int BIT_FULL_SOFT_RESET = 15;
  localparam int BIT_SOFT_RESTART_KEEP_REGS = 14;
  localparam int BIT_LANE_ALL = 7;
  localparam int LANE_SEL_LSB = 5;

  localparam logic [15:0] CONFIG_THREE_WMASK = 16'h0bc1;
  localparam logic [15:0] TEST_LANE_RESV_VALUE = 16'h0400;
  localparam logic [2:0] TEST_LANE_SEL_RESET = 3'h0;
  localparam logic [15:0] RETRY_TIMER_CONFIG_RESET = 16'h141f;

  localparam int IRQ_BITS = 3;
  localparam int IRQ_CABLE_DONE = 0;
  localparam int IRQ_CABLE_FAIL = 1;
  localparam int IRQ_RESTART_DONE = 2;

  localparam int RETRY_STEP_MS = 32;
  localparam int RETRY_MAX_MS = 480;

  localparam int CLK_PERIOD_NS = 5;
  localparam int SOFT_RESET_PULSE_NS = 80;
  localparam int SOFT_RESET_CYCLES = (SOFT_RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ---- phy_config_control_regs.sv ----
// Purpose: Configuration, soft reset and test lane registers of the transceiver, on Wishbone.
// Assumes: Classic Wishbone slave with 32-bit data; registers occupy the low 16 bits.
// Notes: Answers every access one cycle after it is seen; unmapped words read zero.
//
// Notes on behaviour
// - Extended duplex forces full against forced partner.
// - Otherwise duplex follows standard resolution.
// - Robust bit selects deadlock-free crossover.
// - Fast bit speeds forced-100 crossover resolution.
// - Output enable bit picks interrupt or powerdown.
// - Force bit asserts interrupt pin unconditionally.
// - Reserved bits ignore writes, read zero; the test lane register reads them as 0x0400.
// - Writing launch bit starts cable measurement.
// - Complete bit low while measurement pending.
// - Failed bit reports measurement failure.
// - Full soft reset restores defaults, self-clears.
// - Soft restart keeps registers, self-clears.
// - Selector top bit drives all lanes.
// - Otherwise low two bits pick one lane.
// - Retry code maps to 32 ms steps.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module phy_config_control_regs
  import phy_cfg_pkg::*;
#(
  parameter int RESTART_CYCLES = SOFT_RESET_CYCLES,
  parameter int FULL_RESET_CYCLES = SOFT_RESET_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic stb_i,
  input wire logic cyc_i,
  output logic ack_o,
  output logic irq_o,
  input wire logic irq_or_powerdown_pad_i,
  output logic irq_or_powerdown_pad_o,
  output logic irq_or_powerdown_pad_oe_o,
  output logic powerdown_o,
  input wire logic partner_forced_100_i,
  input wire logic ieee_full_duplex_i,
  output logic full_duplex_o,
  output logic robust_mdix_o,
  output logic fast_mdix_o,
  output logic [8:0] crossover_retry_period_o,
  output logic cable_test_start_o,
  input wire logic cable_test_end_i,
  input wire logic cable_test_fail_i,
  output logic core_reset_o,
  output logic core_restart_o,
  output logic [3:0] test_lane_enable_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Storage.

  logic ext_fd_q;
  logic robust_mdix_q;
  logic fast_mdix_q;
  logic irq_out_enable_q;
  logic force_irq_q;
  logic cable_test_launch_q;
  logic cable_test_complete_q;
  logic cable_test_failed_q;
  logic [2:0] test_pattern_lane_select_q;
  logic [15:0] retry_timer_config_q;
  logic [IRQ_BITS-1:0] irq_status_q;
  logic [IRQ_BITS-1:0] irq_mask_q;
  logic [IRQ_BITS-1:0] irq_event;
  logic pad_meta_q;
  logic pad_sync_q;
  logic reg_rst;
  logic [5:0] index;
  logic req;
  logic wr_now;
  logic wr_lo;
  logic wr_hi;
  logic [15:0] rd_word;
  logic launch_wr;

  pulse_ctrl_if full_ctl ();
  pulse_ctrl_if restart_ctl ();

  // A full soft reset clears the registers in the cycle after the request, so the
  // answer to the write that asked for it is still a normal acknowledge.
  assign reg_rst = rst_i | full_ctl.start;

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone slave.

  assign index = adr_i[7:2];
  assign req = cyc_i & stb_i;
  assign wr_now = req & we_i & ack_o & ce_i;
  assign wr_lo = wr_now & sel_i[0];
  assign wr_hi = wr_now & sel_i[1];

  always_comb begin
    rd_word = 16'h0000;
    case (index)
      IDX_CONFIG_THREE: begin
        rd_word[BIT_EXT_FULL_DUPLEX] = ext_fd_q;
        rd_word[BIT_ROBUST_MDIX] = robust_mdix_q;
        rd_word[BIT_FAST_MDIX] = fast_mdix_q;
        rd_word[BIT_IRQ_OUT_ENABLE] = irq_out_enable_q;
        rd_word[BIT_FORCE_IRQ] = force_irq_q;
        rd_word[BIT_CABLE_TEST_FAILED] = cable_test_failed_q;
        rd_word[BIT_CABLE_TEST_COMPLETE] = cable_test_complete_q;
        rd_word[BIT_CABLE_TEST_LAUNCH] = cable_test_launch_q;
      end
      IDX_SOFT_RESET_CONTROL: begin
        rd_word[BIT_FULL_SOFT_RESET] = full_ctl.busy;
        rd_word[BIT_SOFT_RESTART_KEEP_REGS] = restart_ctl.busy;
      end
      IDX_TEST_LANE_CONTROL: begin
        rd_word = TEST_LANE_RESV_VALUE;
        rd_word[BIT_LANE_ALL:LANE_SEL_LSB] = test_pattern_lane_select_q;
      end
      IDX_CROSSOVER_RETRY_TIMER_CONFIG: begin
        rd_word = retry_timer_config_q;
      end
      IDX_IRQ_STATUS: begin
        rd_word[IRQ_BITS-1:0] = irq_status_q;
      end
      IDX_IRQ_MASK: begin
        rd_word[IRQ_BITS-1:0] = irq_mask_q;
      end
      default: begin
        rd_word = 16'h0000;
      end
    endcase
  end

  // Ack follows the request by one cycle and drops in the cycle after it, so a
  // master that holds cyc and stb never sees two answers for one request.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_o <= req & ~ack_o;
      if (req & ~ack_o) begin
        dat_o <= {16'h0000, rd_word};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration register three. Reserved bits have no storage at all.

  assign launch_wr = wr_lo && index == IDX_CONFIG_THREE && dat_i[BIT_CABLE_TEST_LAUNCH];

  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      ext_fd_q <= 1'b0;
      robust_mdix_q <= 1'b0;
      fast_mdix_q <= 1'b0;
      irq_out_enable_q <= 1'b0;
      force_irq_q <= 1'b0;
      cable_test_launch_q <= 1'b0;
    end else if (ce_i && index == IDX_CONFIG_THREE) begin
      if (wr_hi) begin
        ext_fd_q <= dat_i[BIT_EXT_FULL_DUPLEX];
        robust_mdix_q <= dat_i[BIT_ROBUST_MDIX];
        fast_mdix_q <= dat_i[BIT_FAST_MDIX];
      end
      if (wr_lo) begin
        irq_out_enable_q <= dat_i[BIT_IRQ_OUT_ENABLE];
        force_irq_q <= dat_i[BIT_FORCE_IRQ];
        cable_test_launch_q <= dat_i[BIT_CABLE_TEST_LAUNCH];
      end
    end
  end

  // Cable measurement status. A launch in the same cycle as an end wins, since
  // the new measurement is the one that software now waits for.
  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      cable_test_complete_q <= 1'b1;
      cable_test_failed_q <= 1'b0;
    end else if (ce_i) begin
      if (launch_wr) begin
        cable_test_complete_q <= 1'b0;
        cable_test_failed_q <= 1'b0;
      end else if (cable_test_end_i && !cable_test_complete_q) begin
        cable_test_complete_q <= 1'b1;
        cable_test_failed_q <= cable_test_fail_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cable_test_start_o <= 1'b0;
    end else if (ce_i) begin
      cable_test_start_o <= launch_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Soft reset and restart. The bits read as one until the pulse has ended.

  assign full_ctl.start = wr_hi && index == IDX_SOFT_RESET_CONTROL
                          && dat_i[BIT_FULL_SOFT_RESET];
  assign restart_ctl.start = wr_hi && index == IDX_SOFT_RESET_CONTROL
                             && dat_i[BIT_SOFT_RESTART_KEEP_REGS];

  self_clear_pulse #(
    .CYCLES(FULL_RESET_CYCLES)
  ) u_full_reset (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .ctl(full_ctl)
  );

  self_clear_pulse #(
    .CYCLES(RESTART_CYCLES)
  ) u_restart (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .ctl(restart_ctl)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_reset_o <= 1'b0;
      core_restart_o <= 1'b0;
    end else if (ce_i) begin
      core_reset_o <= full_ctl.busy;
      core_restart_o <= restart_ctl.busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Test lane selector and retry timer configuration.

  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      test_pattern_lane_select_q <= TEST_LANE_SEL_RESET;
    end else if (wr_lo && index == IDX_TEST_LANE_CONTROL) begin
      test_pattern_lane_select_q <= dat_i[BIT_LANE_ALL:LANE_SEL_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      retry_timer_config_q <= RETRY_TIMER_CONFIG_RESET;
    end else if (index == IDX_CROSSOVER_RETRY_TIMER_CONFIG) begin
      if (wr_lo) begin
        retry_timer_config_q[7:0] <= dat_i[7:0];
      end
      if (wr_hi) begin
        retry_timer_config_q[15:8] <= dat_i[15:8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      test_lane_enable_o <= 4'h0;
    end else if (ce_i) begin
      if (test_pattern_lane_select_q[2]) begin
        test_lane_enable_o <= 4'hf;
      end else begin
        test_lane_enable_o <= 4'h1 << test_pattern_lane_select_q[1:0];
      end
    end
  end

  // The all-ones code is pinned to the longest period; the other codes step by
  // the base period from one step at code zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crossover_retry_period_o <= 9'h000;
    end else if (ce_i) begin
      if (!robust_mdix_q) begin
        crossover_retry_period_o <= 9'h000;
      end else if (retry_timer_config_q[3:0] == 4'hf) begin
        crossover_retry_period_o <= 9'(RETRY_MAX_MS);
      end else begin
        crossover_retry_period_o <= 9'((retry_timer_config_q[3:0] + 5'h01)
                                       * RETRY_STEP_MS);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Duplex and crossover mode outputs.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      full_duplex_o <= 1'b0;
      robust_mdix_o <= 1'b0;
      fast_mdix_o <= 1'b0;
    end else if (ce_i) begin
      if (ext_fd_q && partner_forced_100_i) begin
        full_duplex_o <= 1'b1;
      end else begin
        full_duplex_o <= ieee_full_duplex_i;
      end
      robust_mdix_o <= robust_mdix_q;
      fast_mdix_o <= fast_mdix_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and the shared pad.

  assign irq_event[IRQ_CABLE_DONE] = cable_test_end_i & ~cable_test_complete_q & ~launch_wr;
  assign irq_event[IRQ_CABLE_FAIL] = irq_event[IRQ_CABLE_DONE] & cable_test_fail_i;
  assign irq_event[IRQ_RESTART_DONE] = restart_ctl.done;

  // A new event in the cycle of its clear keeps the bit set.
  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      irq_status_q <= '0;
    end else if (ce_i) begin
      for (int i = 0; i < IRQ_BITS; i++) begin
        if (irq_event[i]) begin
          irq_status_q[i] <= 1'b1;
        end else if (wr_lo && index == IDX_IRQ_STATUS && dat_i[i]) begin
          irq_status_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      irq_mask_q <= '0;
    end else if (wr_lo && index == IDX_IRQ_MASK) begin
      irq_mask_q <= dat_i[IRQ_BITS-1:0];
    end
  end

  // The pad input is asynchronous, so it passes two flops before anything reads it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_meta_q <= 1'b1;
      pad_sync_q <= 1'b1;
    end else if (ce_i) begin
      pad_meta_q <= irq_or_powerdown_pad_i;
      pad_sync_q <= pad_meta_q;
    end
  end

  // The pad is active low in both roles: low drives an interrupt out, or
  // requests power-down when it is an input.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      irq_or_powerdown_pad_o <= 1'b1;
      irq_or_powerdown_pad_oe_o <= 1'b0;
      powerdown_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(irq_status_q & irq_mask_q) | force_irq_q;
      irq_or_powerdown_pad_o <= ~(|(irq_status_q & irq_mask_q) | force_irq_q);
      irq_or_powerdown_pad_oe_o <= irq_out_enable_q;
      powerdown_o <= ~irq_out_enable_q & ~pad_sync_q;
    end
  end

endmodule
`default_nettype wire

// ---- pulse_ctrl_if.sv ----
// Purpose: Carrier between the register bank and its self-clearing pulse timers.
// Assumes: Single clock domain.
// Notes: start is a one-cycle request; busy spans the pulse; done marks its end.
`timescale 1ns/10ps
`default_nettype none
interface pulse_ctrl_if;
  logic start;
  logic busy;
  logic done;
  modport owner (output start, input busy, input done);
  modport timer (input start, output busy, output done);
endinterface
`default_nettype wire

// ---- self_clear_pulse.sv ----
// Purpose: Holds a busy level for a fixed number of cycles after a start request.
// Assumes: Start is ignored while already busy.
// Notes: Done pulses for one cycle as busy falls.
`timescale 1ns/10ps
`default_nettype none
module self_clear_pulse #(
  parameter int CYCLES = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  pulse_ctrl_if.timer ctl
);
  logic [15:0] count_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= 16'h0000;
      ctl.busy <= 1'b0;
      ctl.done <= 1'b0;
    end else if (ce_i) begin
      ctl.done <= 1'b0;
      if (!ctl.busy && ctl.start) begin
        count_q <= 16'(CYCLES - 1);
        ctl.busy <= 1'b1;
      end else if (ctl.busy) begin
        if (count_q == 16'h0000) begin
          ctl.busy <= 1'b0;
          ctl.done <= 1'b1;
        end else begin
          count_q <= count_q - 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Purpose: Self-checking bench for the configuration register bank.
// Assumes: Reset and restart pulses shortened to four cycles.
// Notes: A cable engine model answers every launch.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import phy_cfg_pkg::*;
  localparam int PULSE = 4;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic irq_or_powerdown_pad_i = 1'b1, partner_forced_100_i = 1'b0;
  logic ieee_full_duplex_i = 1'b1, fail_sel = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_o;
  logic ack_o, irq_o, irq_or_powerdown_pad_o, irq_or_powerdown_pad_oe_o, powerdown_o;
  logic full_duplex_o, robust_mdix_o, fast_mdix_o, cable_test_start_o, cable_test_end_i;
  logic cable_test_fail_i, core_reset_o, core_restart_o;
  logic [8:0] crossover_retry_period_o;
  logic [3:0] test_lane_enable_o;
  int num_errors = 0, n_compared = 0, cycles = 0, n_starts = 0, n_rst_hi = 0, n_rs_hi = 0;
  phy_config_control_regs #(.RESTART_CYCLES(PULSE), .FULL_RESET_CYCLES(PULSE)) i_dut (.*);
  cable_test_engine_model i_eng (.clk_i(clk_i), .start_i(cable_test_start_o),
    .fail_sel_i(fail_sel), .end_o(cable_test_end_i), .fail_o(cable_test_fail_i));
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cable_test_start_o === 1'b1) n_starts++;
    if (core_reset_o === 1'b1) n_rst_hi++;
    if (core_restart_o === 1'b1) n_rs_hi++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // The request is held until ack is sampled, so slow answers are tolerated.
  // A slave that never answers is caught by the cycle ceiling, not here.
  task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] d,
                     output logic [31:0] q);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {16'h0000, d};
    sel_i <= 4'h3;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 16'h0000, q);
    check(q, {16'h0000, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    check(32'(test_lane_enable_o), 32'h0000_0001);
    rd(8'h78, 16'h0002);
    rd(8'h7c, 16'h0000);
    rd(8'h94, 16'h0400);
    rd(8'hb0, 16'h141f);
    rd(8'hfc, 16'h0000);
    irq_or_powerdown_pad_i <= 1'b0;
    tick(4);
    check(32'(powerdown_o), 32'h0000_0001);
    irq_or_powerdown_pad_i <= 1'b1;
  endtask
  task automatic t_config();
    wr(8'h78, 16'hfffe);
    rd(8'h78, 16'h0bc2);
    tick(3);
    check(32'({robust_mdix_o, fast_mdix_o, irq_or_powerdown_pad_oe_o, irq_o}), 32'h0000_000f);
    check(32'(crossover_retry_period_o), 32'h0000_01e0);
    wr(8'hb0, 16'h1410);
    tick(3);
    check(32'(crossover_retry_period_o), 32'h0000_0020);
    partner_forced_100_i <= 1'b1;
    ieee_full_duplex_i <= 1'b0;
    tick(3);
    check(32'(full_duplex_o), 32'h0000_0001);
    wr(8'h78, 16'h0000);
    tick(3);
    check(32'({full_duplex_o, irq_o, crossover_retry_period_o}), 32'h0000_0000);
    wr(8'h7c, 16'h3fff);
    rd(8'h7c, 16'h0000);
  endtask
  task automatic t_lanes();
    for (int v = 0; v < 5; v++) begin
      wr(8'h94, 16'hff1f | 16'(v << 5));
      tick(2);
      check(32'(test_lane_enable_o), (v == 4) ? 32'h0000_000f : 32'(1 << v));
      rd(8'h94, 16'h0400 | 16'(v << 5));
    end
  endtask
  task automatic t_cable();
    fail_sel <= 1'b1;
    wr(8'hc4, 16'h0003);
    wr(8'h78, 16'h0001);
    rd(8'h78, 16'h0001);
    tick(10);
    rd(8'h78, 16'h0007);
    rd(8'hc0, 16'h0003);
    check(32'(irq_o), 32'h0000_0001);
    wr(8'hc0, 16'h0003);
    tick(2);
    check(32'(irq_o), 32'h0000_0000);
    fail_sel <= 1'b0;
    wr(8'hc4, 16'h0000);
    wr(8'h78, 16'h0001);
    tick(10);
    rd(8'h78, 16'h0003);
    check(32'({irq_o, 31'(n_starts)}), 32'h0000_0002);
    wr(8'hc0, 16'h0001);
  endtask
  // With the clock enable low nothing may move, not even a registered copy.
  task automatic t_freeze();
    ce_i <= 1'b0;
    ieee_full_duplex_i <= 1'b1;
    tick(3);
    check(32'(full_duplex_o), 32'h0000_0000);
    ce_i <= 1'b1;
    tick(2);
    check(32'(full_duplex_o), 32'h0000_0001);
    ieee_full_duplex_i <= 1'b0;
  endtask
  task automatic t_resets();
    wr(8'h78, 16'h0800);
    wr(8'h7c, 16'h4000);
    rd(8'h7c, 16'h4000);
    tick(PULSE + 4);
    check(32'(n_rs_hi), 32'(PULSE));
    rd(8'h78, 16'h0802);
    rd(8'hc0, 16'h0004);
    rd(8'h7c, 16'h0000);
    wr(8'h7c, 16'h8000);
    rd(8'h7c, 16'h8000);
    tick(PULSE + 4);
    check(32'(n_rst_hi), 32'(PULSE));
    rd(8'h78, 16'h0002);
    rd(8'h7c, 16'h0000);
    rd(8'hc0, 16'h0000);
    rd(8'h94, 16'h0400);
    rd(8'hb0, 16'h141f);
  endtask
  initial begin
    tick(6);
    rst_i <= 1'b0;
    tick(3);
    t_defaults();
    t_config();
    t_lanes();
    t_freeze();
    t_cable();
    t_resets();
    final_report();
  end
endmodule
`default_nettype wire
